//--- design/timer16_pkg.sv
// Behaviour
// RULE_01: Power gate bit set keeps timer disabled.
// RULE_02: Counter, compares, capture are 16-bit registers.
// RULE_03: Control registers are 8-bit, always accessible.
// RULE_04: Each request flagged, gated by mask bit.
// RULE_05: Tick from prescaler or external pin edge.
// RULE_06: No clock source means counter holds.
// RULE_07: Compare registers checked against counter continuously.
// RULE_08: Compare match sets its channel flag.
// RULE_09: Waveform generator drives compare output pins.
// RULE_10: Capture copies counter on selected edge.
// RULE_11: Optional noise filter on capture trigger.
// RULE_12: Top is fixed, compare A, or capture.
// RULE_13: Compare A as PWM top: buffered, no output.
// RULE_14: Capture register may serve as top.
// RULE_15: Bottom signalled when count equals zero.
// RULE_16: Max signalled when count is all ones.
// RULE_17: Three compare channels, one capture unit.
// RULE_18: Only first instance has external count pin.
// RULE_19: Shared high-byte latch, low byte moves sixteen.
// RULE_20: Software writes high first, reads low first.
// RULE_21: Counter write beats clear or count.
// RULE_22: Reset clears all registers, flags, enables.
package timer16_pkg;

	// ==========================================================
	// Register selects for the byte port.
	localparam logic [3:0] SEL_CNT_L  = 4'h0;
	localparam logic [3:0] SEL_CNT_H  = 4'h1;
	localparam logic [3:0] SEL_CMPA_L = 4'h2;
	localparam logic [3:0] SEL_CMPA_H = 4'h3;
	localparam logic [3:0] SEL_CMPB_L = 4'h4;
	localparam logic [3:0] SEL_CMPB_H = 4'h5;
	localparam logic [3:0] SEL_CMPC_L = 4'h6;
	localparam logic [3:0] SEL_CMPC_H = 4'h7;
	localparam logic [3:0] SEL_CAP_L  = 4'h8;
	localparam logic [3:0] SEL_CAP_H  = 4'h9;
	localparam logic [3:0] SEL_CTL_A  = 4'hA;
	localparam logic [3:0] SEL_CTL_B  = 4'hB;
	localparam logic [3:0] SEL_CTL_C  = 4'hC;
	localparam logic [3:0] SEL_FLAG   = 4'hD;
	localparam logic [3:0] SEL_MASK   = 4'hE;

	// ==========================================================
	// Limits and reset values.
	localparam logic [15:0] CNT_BOTTOM = 16'h0000;
	localparam logic [15:0] CNT_MAX    = 16'hFFFF;
	localparam logic [15:0] TOP_8BIT   = 16'h00FF;
	localparam logic [15:0] TOP_9BIT   = 16'h01FF;
	localparam logic [15:0] TOP_10BIT  = 16'h03FF;
	localparam logic [15:0] CNT_ONE    = 16'h0001;
	localparam logic [7:0]  BYTE_ZERO  = 8'h00;

	// ==========================================================
	// Field positions: flag and mask share one layout.
	localparam int BIT_OVF  = 0;
	localparam int BIT_CMPA = 1;
	localparam int BIT_CMPB = 2;
	localparam int BIT_CMPC = 3;
	localparam int BIT_CAP  = 5;
	localparam int NUM_CH   = 3;
	localparam int NC_DEPTH = 4;
	localparam logic [7:0] FLAG_USED = 8'h2F;

	// Prescaler taps.
	localparam logic [9:0] DIV8    = 10'h0007;
	localparam logic [9:0] DIV64   = 10'h003F;
	localparam logic [9:0] DIV256  = 10'h00FF;
	localparam logic [9:0] DIV1024 = 10'h03FF;

	// Clock select codes.
	localparam logic [2:0] CS_STOP = 3'h0;
	localparam logic [2:0] CS_D1   = 3'h1;
	localparam logic [2:0] CS_D8   = 3'h2;
	localparam logic [2:0] CS_D64  = 3'h3;
	localparam logic [2:0] CS_D256 = 3'h4;
	localparam logic [2:0] CS_D1K  = 3'h5;
	localparam logic [2:0] CS_EXTF = 3'h6;
	localparam logic [2:0] CS_EXTR = 3'h7;

	typedef enum logic [3:0] {
		WG_NORMAL, WG_PC8, WG_PC9, WG_PC10, WG_CTC_A, WG_FAST8, WG_FAST9, WG_FAST10,
		WG_PFC_CAP, WG_PFC_A, WG_PC_CAP, WG_PC_A, WG_CTC_CAP, WG_RSVD, WG_FAST_CAP,
		WG_FAST_A
	} wgm_t;

	// Byte access port of the processor.
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [3:0] sel;
		logic [7:0] wdata;
	} cpu_req_t;

	// Event pins, raw; the core synchronises them into its clock domain.
	typedef struct packed {
		logic ext_count_pin;
		logic capture_in_pin;
		logic comparator_out;
	} pins_t;

endpackage

//--- design/sixteen_bit_timer_core.sv
module sixteen_bit_timer_core
	import timer16_pkg::*;
#(
	parameter bit HAS_EXT_PIN = 1'b1
) (
	// Clock and reset.
	input  wire logic         i_mclk,
	input  wire logic         i_reset,
	// Power gate and processor byte port.
	input  wire logic         i_power_gate,
	input  wire cpu_req_t     i_cpu,
	output logic      [7:0]   o_rdata,
	// Event pins.
	input  wire pins_t        i_pins,
	// Waveform outputs, interrupt requests and count status.
	output logic      [2:0]   o_compare_out_pin,
	output logic      [7:0]   o_irq_req,
	output logic              o_bottom,
	output logic              o_max
);

	// ==========================================================
	// Pin synchronisers.
	pins_t sync1;
	pins_t sync2;
	always_ff @(posedge i_mclk) begin
		sync1 <= i_pins;
		sync2 <= sync1;
	end

	// ==========================================================
	// Architectural state.
	logic [15:0] count_value;
	logic [15:0] compare_value_x [NUM_CH];
	logic [15:0] compare_buf     [NUM_CH];
	logic [15:0] capture_value;
	logic [7:0]  timer_control_regs [3];
	logic [7:0]  irq_flag_reg;
	logic [7:0]  irq_mask_reg;
	logic [7:0]  high_latch;
	logic [9:0]  prescale;
	logic        ext_prev;
	logic        count_down;
	logic [2:0]  wave;
	logic [NC_DEPTH-1:0] nc_shift;
	logic        cap_level;
	logic [7:0]  rdata;

	logic [15:0] next_count_value;
	logic [15:0] next_compare_value_x [NUM_CH];
	logic [15:0] next_compare_buf     [NUM_CH];
	logic [15:0] next_capture_value;
	logic [7:0]  next_timer_control_regs [3];
	logic [7:0]  next_irq_flag_reg;
	logic [7:0]  next_irq_mask_reg;
	logic [7:0]  next_high_latch;
	logic [9:0]  next_prescale;
	logic        next_ext_prev;
	logic        next_count_down;
	logic [2:0]  next_wave;
	logic [NC_DEPTH-1:0] next_nc_shift;
	logic        next_cap_level;
	logic [7:0]  next_rdata;

	// ==========================================================
	// Control field decode.
	logic [2:0]  cs;
	wgm_t        wgm;
	logic        enabled;
	logic        tick;
	logic        ext_now;
	logic [15:0] top;
	logic        use_a_top;
	logic        is_pwm;
	logic        is_dual;
	logic [NUM_CH-1:0] match;
	logic [1:0]  com_mode [NUM_CH];
	logic        at_top;
	logic        cap_src;
	logic        cap_edge;

	function automatic logic [1:0] com_of(input int ch, input logic [7:0] ctl);
		com_of = ctl[7 - 2 * ch -: 2];
	endfunction

	function automatic logic is_lo(input logic [3:0] sel, input logic [3:0] lo);
		is_lo = (sel == lo);
	endfunction

	assign enabled   = !i_power_gate;                                          // [RULE_01]
	assign cs        = timer_control_regs[1][2:0];
	assign wgm       = wgm_t'({timer_control_regs[1][4:3], timer_control_regs[0][1:0]});
	assign ext_now   = HAS_EXT_PIN ? sync2.ext_count_pin : 1'b0;                // [RULE_18]
	assign use_a_top = (wgm == WG_CTC_A) || (wgm == WG_PFC_A) || (wgm == WG_PC_A)
			|| (wgm == WG_FAST_A);
	assign is_pwm    = (wgm != WG_NORMAL) && (wgm != WG_CTC_A) && (wgm != WG_CTC_CAP);
	assign is_dual   = (wgm == WG_PC8) || (wgm == WG_PC9) || (wgm == WG_PC10)
			|| (wgm == WG_PFC_CAP) || (wgm == WG_PFC_A) || (wgm == WG_PC_CAP)
			|| (wgm == WG_PC_A);

	// Tick selection: prescaler taps or an edge of the external pin.
	always_comb begin
		case (cs)                                                              // [RULE_05]
			CS_STOP: tick = 1'b0;                                              // [RULE_06]
			CS_D1:   tick = 1'b1;
			CS_D8:   tick = (prescale[2:0] == DIV8[2:0]);
			CS_D64:  tick = (prescale[5:0] == DIV64[5:0]);
			CS_D256: tick = (prescale[7:0] == DIV256[7:0]);
			CS_D1K:  tick = (prescale == DIV1024);
			CS_EXTF: tick = HAS_EXT_PIN && ext_prev && !ext_now;               // [RULE_18]
			CS_EXTR: tick = HAS_EXT_PIN && !ext_prev && ext_now;
			default: tick = 1'b0;
		endcase
		tick = tick && enabled;
	end

	// Top selection.
	always_comb begin
		case (wgm)                                                             // [RULE_12]
			WG_PC8, WG_FAST8:   top = TOP_8BIT;
			WG_PC9, WG_FAST9:   top = TOP_9BIT;
			WG_PC10, WG_FAST10: top = TOP_10BIT;
			WG_CTC_A, WG_PFC_A, WG_PC_A, WG_FAST_A: top = compare_value_x[0];
			WG_PFC_CAP, WG_PC_CAP, WG_CTC_CAP, WG_FAST_CAP: top = capture_value; // [RULE_14]
			default: top = CNT_MAX;
		endcase
	end

	assign at_top  = (count_value == top);
	assign o_bottom = (count_value == CNT_BOTTOM);                             // [RULE_15]
	assign o_max    = (count_value == CNT_MAX);                                // [RULE_16]

	genvar g;
	generate
		for (g = 0; g < NUM_CH; g++) begin : g_cmp
			assign match[g] = (count_value == compare_value_x[g]);             // [RULE_07]
			assign com_mode[g] = com_of(g, timer_control_regs[0]);
		end
	endgenerate

	// Noise canceller: the trigger must hold for NC_DEPTH samples.
	assign cap_src  = timer_control_regs[2][0] ? sync2.comparator_out : sync2.capture_in_pin;
	assign cap_edge = (next_cap_level != cap_level) &&
			(next_cap_level == timer_control_regs[1][6]);

	// ==========================================================
	// Next-state logic.
	always_comb begin
		next_count_value  = count_value;
		next_capture_value = capture_value;
		next_timer_control_regs = timer_control_regs;
		next_irq_flag_reg = irq_flag_reg;
		next_irq_mask_reg = irq_mask_reg;
		next_high_latch   = high_latch;
		next_compare_value_x = compare_value_x;
		next_compare_buf  = compare_buf;
		next_prescale     = enabled ? prescale + 10'h001 : prescale;
		next_ext_prev     = ext_now;
		next_count_down   = count_down;
		next_wave         = wave;
		next_rdata        = rdata;
		next_nc_shift     = {nc_shift[NC_DEPTH-2:0], cap_src};
		if (!timer_control_regs[1][7])
			next_cap_level = cap_src;
		else if (&nc_shift || ~|nc_shift)                                      // [RULE_11]
			next_cap_level = nc_shift[0];
		else
			next_cap_level = cap_level;

		// Counting, flags and waveforms on each tick.
		if (tick) begin
			if (is_dual) begin
				if (at_top && !count_down)
					next_count_down = 1'b1;
				else if (count_value == CNT_ONE && count_down)
					next_count_down = 1'b0;
				next_count_value = (count_down || at_top) ? count_value - CNT_ONE
						: count_value + CNT_ONE;
				if (o_bottom)
					next_irq_flag_reg[BIT_OVF] = 1'b1;
			end else begin
				next_count_value = at_top ? CNT_BOTTOM : count_value + CNT_ONE;
				if ((wgm == WG_NORMAL) ? o_max : (at_top && is_pwm))
					next_irq_flag_reg[BIT_OVF] = 1'b1;
			end
			// Double-buffered compares load at top in PWM modes.
			if (is_pwm && at_top)                                              // [RULE_13]
				next_compare_value_x = compare_buf;
			for (int ch = 0; ch < NUM_CH; ch++) begin
				if (match[ch])
					next_irq_flag_reg[BIT_CMPA + ch] = 1'b1;                   // [RULE_08]
				if (!(ch == 0 && use_a_top && is_pwm)) begin                   // [RULE_13]
					if (match[ch] && com_mode[ch] == 2'b01 && !is_pwm)
						next_wave[ch] = !wave[ch];                             // [RULE_09]
					else if (match[ch] && com_mode[ch][1])
						next_wave[ch] = com_mode[ch][0] ^ count_down;
					else if (at_top && !is_dual && is_pwm && com_mode[ch][1])
						next_wave[ch] = !com_mode[ch][0];
				end
			end
		end

		// Capture on the selected edge, unless top equals the register's value outside normal and compare-A-top modes.
		if (enabled && cap_edge) begin
			if (top != capture_value || use_a_top || wgm == WG_NORMAL)
				next_capture_value = count_value;                              // [RULE_10]
			next_irq_flag_reg[BIT_CAP] = 1'b1;
		end

		// Processor access.
		if (i_cpu.rd) begin                                                    // [RULE_02]
			case (i_cpu.sel)
				SEL_CNT_L: begin
					next_rdata = count_value[7:0];
					next_high_latch = count_value[15:8];                       // [RULE_19]
				end
				SEL_CAP_L: begin
					next_rdata = capture_value[7:0];
					next_high_latch = capture_value[15:8];
				end
				SEL_CNT_H, SEL_CAP_H: next_rdata = high_latch;                 // [RULE_20]
				SEL_CMPA_L: next_rdata = compare_buf[0][7:0];
				SEL_CMPA_H: next_rdata = compare_buf[0][15:8];
				SEL_CMPB_L: next_rdata = compare_buf[1][7:0];
				SEL_CMPB_H: next_rdata = compare_buf[1][15:8];
				SEL_CMPC_L: next_rdata = compare_buf[2][7:0];
				SEL_CMPC_H: next_rdata = compare_buf[2][15:8];
				SEL_CTL_A:  next_rdata = timer_control_regs[0];                // [RULE_03]
				SEL_CTL_B:  next_rdata = timer_control_regs[1];
				SEL_CTL_C:  next_rdata = timer_control_regs[2];
				SEL_FLAG:   next_rdata = irq_flag_reg;
				SEL_MASK:   next_rdata = irq_mask_reg;
				default:    next_rdata = BYTE_ZERO;
			endcase
		end
		if (i_cpu.wr) begin
			case (i_cpu.sel)
				SEL_CNT_H, SEL_CMPA_H, SEL_CMPB_H, SEL_CMPC_H, SEL_CAP_H:
					next_high_latch = i_cpu.wdata;                             // [RULE_20]
				SEL_CNT_L: next_count_value = {high_latch, i_cpu.wdata};       // [RULE_21]
				SEL_CAP_L: next_capture_value = {high_latch, i_cpu.wdata};     // [RULE_19]
				SEL_CTL_A: next_timer_control_regs[0] = i_cpu.wdata;
				SEL_CTL_B: next_timer_control_regs[1] = i_cpu.wdata;
				SEL_CTL_C: next_timer_control_regs[2] = i_cpu.wdata;
				SEL_MASK:  next_irq_mask_reg = i_cpu.wdata & FLAG_USED;
				// Writing one clears a set flag, even if its event repeats this cycle.
				SEL_FLAG:  next_irq_flag_reg = next_irq_flag_reg
						& ~(i_cpu.wdata & irq_flag_reg & ~(next_irq_flag_reg ^ irq_flag_reg));
				default: ;
			endcase
			for (int ch = 0; ch < NUM_CH; ch++) begin
				if (is_lo(i_cpu.sel, SEL_CMPA_L + 4'(2 * ch))) begin
					next_compare_buf[ch] = {high_latch, i_cpu.wdata};          // [RULE_19]
					if (!is_pwm)
						next_compare_value_x[ch] = {high_latch, i_cpu.wdata};
				end
			end
		end
	end

	// ==========================================================
	// Registers.
	always_ff @(posedge i_mclk) begin
		if (i_reset) begin                                                     // [RULE_22]
			count_value  <= CNT_BOTTOM;
			compare_value_x <= '{default: CNT_BOTTOM};
			compare_buf  <= '{default: CNT_BOTTOM};
			capture_value <= CNT_BOTTOM;
			timer_control_regs <= '{default: BYTE_ZERO};
			irq_flag_reg <= BYTE_ZERO;
			irq_mask_reg <= BYTE_ZERO;
			high_latch   <= BYTE_ZERO;
			prescale     <= '0;
			ext_prev     <= 1'b0;
			count_down   <= 1'b0;
			wave         <= '0;
			nc_shift     <= '0;
			cap_level    <= 1'b0;
			rdata        <= BYTE_ZERO;
		end else begin
			count_value  <= next_count_value;
			compare_value_x <= next_compare_value_x;
			compare_buf  <= next_compare_buf;
			capture_value <= next_capture_value;
			timer_control_regs <= next_timer_control_regs;
			irq_flag_reg <= next_irq_flag_reg;
			irq_mask_reg <= next_irq_mask_reg;
			high_latch   <= next_high_latch;
			prescale     <= next_prescale;
			ext_prev     <= next_ext_prev;
			count_down   <= next_count_down;
			wave         <= next_wave;
			nc_shift     <= next_nc_shift;
			cap_level    <= next_cap_level;
			rdata        <= next_rdata;
		end
	end

	// ==========================================================
	// Outputs; a pin is only driven while its compare mode is on.
	generate
		for (g = 0; g < NUM_CH; g++) begin : g_out
			assign o_compare_out_pin[g] = (com_of(g, timer_control_regs[0]) != 2'b00)
					&& wave[g];                                                // [RULE_17]
		end
	endgenerate
	assign o_irq_req = irq_flag_reg & irq_mask_reg;                            // [RULE_04]
	assign o_rdata   = rdata;

endmodule

//--- tb/timer_core_asserts.sv
module timer_core_asserts
	import timer16_pkg::*;
(
	// Clock and reset.
	input wire logic       i_mclk,
	input wire logic       i_reset,
	// Inputs of the core.
	input wire logic       i_power_gate,
	input wire cpu_req_t   i_cpu,
	input wire pins_t      i_pins,
	// Outputs of the core.
	input wire logic [7:0] o_rdata,
	input wire logic [2:0] o_compare_out_pin,
	input wire logic [7:0] o_irq_req,
	input wire logic       o_bottom,
	input wire logic       o_max
);
	// ====
	// Properties.
	default clocking @(posedge i_mclk);
	endclocking
	default disable iff (i_reset);
	sequence s_ctl_wr_rd;
		i_cpu.wr && !i_cpu.rd && i_cpu.sel == SEL_CTL_A
		##1 i_cpu.rd && !i_cpu.wr && i_cpu.sel == SEL_CTL_A;
	endsequence
	property p_reset_clear;
		disable iff (1'b0) i_reset |=> o_irq_req == BYTE_ZERO && o_bottom
			&& o_compare_out_pin == 3'h0;
	endproperty
	property p_excl;
		!(o_bottom && o_max);
	endproperty
	property p_unused;
		(o_irq_req & ~FLAG_USED) == BYTE_ZERO;
	endproperty
	property p_unmapped;
		i_cpu.rd && i_cpu.sel == 4'hF |=> o_rdata == BYTE_ZERO;
	endproperty
	property p_rd_hold;
		!i_cpu.rd |=> $stable(o_rdata);
	endproperty
	property p_ctl_back;
		s_ctl_wr_rd |=> o_rdata == $past(i_cpu.wdata, 2);
	endproperty
	property p_mask_off;
		i_cpu.wr && i_cpu.sel == SEL_MASK && i_cpu.wdata == BYTE_ZERO |=> o_irq_req == BYTE_ZERO;
	endproperty
	// Three quiet cycles; the gate masks the tick in the cycle it closes, so no tick is in flight.
	property p_gate_hold;
		(i_power_gate && !i_cpu.wr)[*3] |=> $stable(o_bottom) && $stable(o_max);
	endproperty
	property p_cnt_pair;
		i_cpu.wr && i_power_gate && i_cpu.sel == SEL_CNT_H
		##1 i_cpu.wr && i_power_gate && i_cpu.sel == SEL_CNT_L
		##1 i_cpu.rd && i_power_gate && i_cpu.sel == SEL_CNT_L
		|=> o_rdata == $past(i_cpu.wdata, 2);
	endproperty
	a_reset_clear: assert property (p_reset_clear) else $error("state kept after reset");
	a_excl: assert property (p_excl) else $error("bottom and max together");
	a_unused: assert property (p_unused) else $error("unused request bit high");
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
	a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
	a_ctl_back: assert property (p_ctl_back) else $error("control readback wrong");
	a_mask_off: assert property (p_mask_off) else $error("masked request high");
	a_gate_hold: assert property (p_gate_hold) else $error("gated count moved");
	a_cnt_pair: assert property (p_cnt_pair) else $error("count pair wrong");
	c_ctl: cover property (s_ctl_wr_rd);
	c_max: cover property (o_max);
	c_cap: cover property (o_irq_req[BIT_CAP]);
endmodule

//--- tb/timer_pins_model.sv
module timer_pins_model
	import timer16_pkg::*;
(
	// Clock and bench commands.
	input  wire logic       i_mclk,
	input  wire logic       i_ext_go,
	input  wire logic       i_cap_go,
	input  wire logic       i_cap_cmp,
	input  wire logic [3:0] i_cap_width,
	// Event lines toward the timer.
	output pins_t           o_pins
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [1:0] phase = 2'h0;
	logic [3:0] left  = 4'h0;
	logic       ext   = 1'b0;
	// ====
	// Capture lines rest low between events, so an old level never reads as a new edge; the count line keeps its last toggled level.
	always @(posedge i_mclk) begin
		phase <= i_ext_go ? phase + 2'h1 : 2'h0;
		if (i_ext_go && phase == 2'h3) begin
			ext <= !ext;
		end
		if (i_cap_go) begin
			left <= i_cap_width;
		end else if (left != 4'h0) begin
			left <= left - 4'h1;
		end
	end
	assign o_pins = '{ext_count_pin: ext, capture_in_pin: !i_cap_cmp && left != 4'h0,
		comparator_out: i_cap_cmp && left != 4'h0};
endmodule

//--- tb/tb_sixteen_bit_timer_core.sv
module tb_sixteen_bit_timer_core
	import timer16_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic        i_mclk       = 1'b0;
	logic        i_reset      = 1'b1;
	logic        i_power_gate = 1'b0;
	logic        ext_go       = 1'b0;
	logic        cap_go       = 1'b0;
	logic        cap_cmp      = 1'b0;
	logic        saw_max      = 1'b0;
	logic [3:0]  cap_width    = 4'h1;
	cpu_req_t    i_cpu        = '0;
	pins_t       pins;
	logic [7:0]  rdata, irq, got8;
	logic [2:0]  wave;
	logic        bottom, at_max;
	logic [15:0] v16, got16, cmp;
	logic [31:0] seed         = 32'h73dd_ebe1;
	int          fails        = 0;
	int          checks_done  = 0;
	int          cycles       = 0;
	int          cnt_model;
	int          dv[5]        = '{1, 8, 64, 256, 1024};
	// ====
	// Clock, parts and watchdog.
	initial begin
		forever #10 i_mclk = ~i_mclk;
	end
	sixteen_bit_timer_core u_sixteen_bit_timer_core (.i_mclk(i_mclk), .i_reset(i_reset),
		.i_power_gate(i_power_gate), .i_cpu(i_cpu), .o_rdata(rdata), .i_pins(pins),
		.o_compare_out_pin(wave), .o_irq_req(irq), .o_bottom(bottom), .o_max(at_max));
	timer_pins_model u_timer_pins_model (.i_mclk(i_mclk), .i_ext_go(ext_go),
		.i_cap_go(cap_go), .i_cap_cmp(cap_cmp), .i_cap_width(cap_width), .o_pins(pins));
	always @(negedge i_mclk) begin
		saw_max <= saw_max | at_max;
	end
	always @(posedge i_mclk) begin
		cycles++;
		if (cycles == 30000) begin
			fails++;
			finish_test();
		end
	end
	// ====
	// Tasks.
	function automatic logic [31:0] xorshift(input logic [31:0] x);
		x ^= x << 13;
		x ^= x >> 17;
		x ^= x << 5;
		return x;
	endfunction
	task automatic chk(input string what, input logic [15:0] lo, hi, got);
		#1;
		checks_done++;
		if ($isunknown(got) || got < lo || got > hi) begin
			fails++;
			$display("[FAIL] %s expected %h..%h seen %h", what, lo, hi, got);
		end
	endtask
	task automatic put(input logic w, r, input logic [3:0] s, input logic [7:0] d);
		@(posedge i_mclk);
		i_cpu <= '{wr: w, rd: r, sel: s, wdata: d};
	endtask
	task automatic idle(input int n);
		repeat (n) put(1'b0, 1'b0, 4'h0, BYTE_ZERO);
	endtask
	task automatic wr16(input logic [3:0] s, input logic [15:0] d);
		put(1'b1, 1'b0, s + 4'h1, d[15:8]);
		put(1'b1, 1'b0, s, d[7:0]);
	endtask
	task automatic rd8(input logic [3:0] s, output logic [7:0] d);
		put(1'b0, 1'b1, s, BYTE_ZERO);
		idle(1);
		#1 d = rdata;
	endtask
	task automatic rd16(input logic [3:0] s, output logic [15:0] d);
		logic [7:0] lo, hi;
		rd8(s, lo);
		rd8(s + 4'h1, hi);
		d = {hi, lo};
	endtask
	task automatic wait_irq(input int b, input int lim);
		idle(1);
		for (int n = 0; n < lim && irq[b] !== 1'b1; n++) begin
			@(negedge i_mclk);
		end
		chk("irq raised", 16'h0001, 16'h0001, 16'(irq[b]));
	endtask
	task automatic pulse();
		cap_go <= 1'b1;
		idle(1);
		cap_go <= 1'b0;
	endtask
	task automatic finish_test();
		$display("checks %0d mismatches %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	// ====
	// Main sequence.
	initial begin
		repeat (3) @(posedge i_mclk);
		i_reset <= 1'b0;
		for (int s = 0; s < 16; s++) begin
			rd8(4'(s), got8);
			chk("reset read", 16'h0000, 16'h0000, 16'(got8));
		end
		chk("reset bottom", 16'h0001, 16'h0001, 16'(bottom));
		for (int s = 10; s < 13; s++) begin
			seed = xorshift(seed);
			v16 = 16'(seed[7:0] & ((s == 11) ? 8'hF8 : (s == 12) ? 8'h01 : 8'hFF));
			put(1'b1, 1'b0, 4'(s), v16[7:0]);
			rd8(4'(s), got8);
			chk("control", v16, v16, 16'(got8));
			put(1'b1, 1'b0, 4'(s), BYTE_ZERO);
		end
		put(1'b1, 1'b0, SEL_MASK, 8'hFF);
		rd8(SEL_MASK, got8);
		chk("mask", 16'(FLAG_USED), 16'(FLAG_USED), 16'(got8));
		put(1'b1, 1'b0, SEL_MASK, BYTE_ZERO);
		seed = xorshift(seed);
		v16 = seed[15:0];
		put(1'b1, 1'b0, SEL_CTL_B, {5'h00, CS_D1});
		i_power_gate <= 1'b1;
		idle(3);
		wr16(SEL_CNT_L, v16);
		rd16(SEL_CNT_L, got16);
		chk("count pair", v16, v16, got16);
		idle(20);
		rd16(SEL_CNT_L, got16);
		chk("gated count", v16, v16, got16);
		chk("bottom", 16'(v16 == CNT_BOTTOM), 16'(v16 == CNT_BOTTOM), 16'(bottom));
		put(1'b1, 1'b0, SEL_CTL_B, BYTE_ZERO);
		// Open the gate only once the stop code is in, so no stray tick slips through.
		idle(1);
		i_power_gate <= 1'b0;
		idle(20);
		rd16(SEL_CNT_L, got16);
		chk("stopped count", v16, v16, got16);
		for (int i = 1; i < 8; i++) begin
			wr16(SEL_CNT_L, CNT_BOTTOM);
			put(1'b1, 1'b0, SEL_CTL_B, {5'h00, 3'(i)});
			ext_go <= (i > 5);
			idle((i > 5) ? 40 : 2047);
			ext_go <= 1'b0;
			idle(6);
			put(1'b1, 1'b0, SEL_CTL_B, BYTE_ZERO);
			rd16(SEL_CNT_L, got16);
			cnt_model = (i > 5) ? 5 : 2054 / dv[i - 1];
			chk("count rate", 16'(cnt_model * 3 / 4), 16'(cnt_model + 3), got16);
		end
		put(1'b1, 1'b0, SEL_MASK, 8'h01);
		put(1'b1, 1'b0, SEL_CTL_B, {5'h00, CS_D1});
		// The low byte lands while ticking; a lost write would never overflow in time.
		wr16(SEL_CNT_L, 16'hFFF0);
		wait_irq(BIT_OVF, 40);
		chk("max seen", 16'h0001, 16'h0001, 16'(saw_max));
		put(1'b1, 1'b0, SEL_CTL_B, BYTE_ZERO);
		put(1'b1, 1'b0, SEL_FLAG, 8'h01);
		idle(1);
		#1 chk("flag cleared", 16'h0000, 16'h0000, 16'(irq));
		cmp = 16'h0028 + 16'(seed[22:16]);
		wr16(SEL_CNT_L, CNT_BOTTOM);
		wr16(SEL_CMPB_L, cmp);
		put(1'b1, 1'b0, SEL_FLAG, 8'hFF);
		put(1'b1, 1'b0, SEL_CTL_A, 8'h10);
		put(1'b1, 1'b0, SEL_MASK, 8'h04);
		put(1'b1, 1'b0, SEL_CTL_B, {5'h00, CS_D1});
		wait_irq(BIT_CMPB, 300);
		put(1'b1, 1'b0, SEL_CTL_B, BYTE_ZERO);
		rd16(SEL_CNT_L, got16);
		chk("match count", cmp, cmp + 16'h0008, got16);
		chk("wave pins", 16'h0002, 16'h0002, 16'(wave));
		put(1'b1, 1'b0, SEL_CTL_B, 8'hC1);
		put(1'b1, 1'b0, SEL_FLAG, 8'hFF);
		put(1'b1, 1'b0, SEL_MASK, 8'h20);
		cap_width <= 4'h2;
		pulse();
		idle(12);
		chk("short spike", 16'h0000, 16'h0000, 16'(irq));
		cap_width <= 4'h9;
		pulse();
		wait_irq(BIT_CAP, 20);
		put(1'b1, 1'b0, SEL_CTL_B, BYTE_ZERO);
		rd16(SEL_CAP_L, got16);
		rd16(SEL_CNT_L, v16);
		chk("capture value", v16 - 16'h0028, v16, got16);
		put(1'b1, 1'b0, SEL_FLAG, 8'hFF);
		put(1'b1, 1'b0, SEL_CTL_C, 8'h01);
		cap_cmp <= 1'b1;
		pulse();
		wait_irq(BIT_CAP, 20);
		for (int m = 0; m < 2; m++) begin
			wr16(SEL_CNT_L, CNT_BOTTOM);
			wr16((m == 0) ? SEL_CMPA_L : SEL_CAP_L, 16'h0010);
			put(1'b1, 1'b0, SEL_CTL_B, (m == 0) ? 8'h09 : 8'h19);
			idle(100);
			put(1'b1, 1'b0, SEL_CTL_B, BYTE_ZERO);
			rd16(SEL_CNT_L, got16);
			chk("top wrap", CNT_BOTTOM, 16'h0010, got16);
		end
		finish_test();
	end
endmodule

bind sixteen_bit_timer_core timer_core_asserts u_timer_core_asserts (.i_mclk(i_mclk),
	.i_reset(i_reset), .i_power_gate(i_power_gate), .i_cpu(i_cpu), .i_pins(i_pins),
	.o_rdata(o_rdata), .o_compare_out_pin(o_compare_out_pin), .o_irq_req(o_irq_req),
	.o_bottom(o_bottom), .o_max(o_max));
